//--- rtl/crps_pkg.sv
// package: register indices, reset values, field layout, modes and helpers
// assumes one 125 MHz clock and a 32-bit apb register slave
`default_nettype none
package crps_pkg;
    localparam int CLK_MHZ = 125;
    localparam int NCH = 2;
    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_MOD0 = 6'h06;
    localparam logic [5:0] IDX_MOD1 = 6'h08;
    localparam logic [5:0] IDX_PRE0 = 6'h0a;
    localparam logic [5:0] IDX_PRE1 = 6'h0c;
    localparam logic [5:0] IDX_SCL0 = 6'h0e;
    localparam logic [5:0] IDX_SCL1 = 6'h0f;
    localparam logic [5:0] IDX_CTRL = 6'h10;
    localparam logic [5:0] IDX_CNT0 = 6'h11;
    localparam logic [5:0] IDX_CNT1 = 6'h12;
    localparam logic [5:0] IDX_PER0 = 6'h13;
    localparam logic [5:0] IDX_PER1 = 6'h14;
    localparam logic [31:0] MOD_LIMIT = 32'h0100_0000;
    localparam logic [31:0] MOD_RST = 32'h0000_0000;
    localparam logic [31:0] PRE_RST = 32'h0000_0000;
    localparam logic [15:0] SCL_RST = 16'h0001;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // control word: per channel a 3-bit mode and a filter enable
    localparam int CH_STRIDE = 4;
    localparam int FILT_BIT = 3;
    localparam int PER_W = 24;
    localparam logic [PER_W-1:0] PER_MAX = 24'hff_ffff;
    localparam int FILT_NS = 32;
    localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);

    typedef enum logic [2:0] {
        MD_COUNT,
        MD_SINGLE_EDGE,
        MD_DOUBLE_EDGE,
        MD_QUAD_EDGE,
        MD_PERIOD_RATE,
        MD_CONT_RATE,
        MD_RATE_MEAS,
        MD_PWM
    } crps_mode_e;

    function automatic logic crps_uses_roll(input crps_mode_e m);
        crps_uses_roll = m inside {MD_COUNT, MD_SINGLE_EDGE, MD_DOUBLE_EDGE, MD_QUAD_EDGE};
    endfunction : crps_uses_roll

    function automatic logic crps_uses_scale(input crps_mode_e m);
        crps_uses_scale = m inside {MD_PERIOD_RATE, MD_CONT_RATE};
    endfunction : crps_uses_scale

    // log2 of the ratio; anything but one bit of 7..0 means no division
    function automatic logic [2:0] crps_scl_shift(input logic [15:0] w);
        crps_scl_shift = 3'h0;
        if ($onehot(w) && w[15:8] == 8'h00) begin
            for (int i = 0; i < 8; i++) begin
                if (w[i]) begin
                    crps_scl_shift = 3'(i);
                end
            end
        end
    endfunction : crps_scl_shift

    function automatic logic [31:0] crps_wmerge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            crps_wmerge[8*i +: 8] = st[i] ? wd[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : crps_wmerge
endpackage : crps_pkg
`default_nettype wire

//--- rtl/crps_scal.sv
// index-pulse filter and power-of-two prescaler for one channel
// assumes z synchronous to ref_clk; step is a one-cycle output and inc holds its value between steps
`default_nettype none
module crps_scal
    import crps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // configuration
    input wire logic filt_en,
    input wire logic [15:0] scl_word,
    input wire logic active,
    // index pulse in, scaled step out
    input wire logic z,
    output logic step,
    output logic [7:0] inc
);
    import crps_pkg::*;

    typedef struct packed {
        logic zf;
        logic [3:0] fcnt;
        logic src_q;
        logic [6:0] div;
        logic step;
        logic [7:0] inc;
    } crps_scal_s;

    crps_scal_s st_ff, nxt_st;
    logic [2:0] shift;
    logic [7:0] dv;
    logic [6:0] mask;
    logic src;
    logic rise;

    assign shift = crps_scl_shift(scl_word);
    assign dv = 8'h01 << shift;
    assign mask = 7'(dv - 8'h01);
    assign src = filt_en ? st_ff.zf : z;
    assign rise = src && !st_ff.src_q;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.step = 1'b0;
        nxt_st.src_q = src;
        // a level change must persist FILT_CYC cycles to pass
        if (z != st_ff.zf) begin
            nxt_st.fcnt = st_ff.fcnt + 4'h1;
            if (st_ff.fcnt == FILT_LAST) begin
                nxt_st.zf = z;
                nxt_st.fcnt = 4'h0;
            end
        end else begin
            nxt_st.fcnt = 4'h0;
        end
        if (!active) begin
            nxt_st.div = 7'h00;
        end else if (rise) begin
            if (st_ff.div >= mask) begin
                nxt_st.div = 7'h00;
                nxt_st.step = 1'b1;
                nxt_st.inc = dv;
            end else begin
                nxt_st.div = st_ff.div + 7'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign step = st_ff.step;
    assign inc = st_ff.inc;

    no_scale_a: assert property (@(posedge ref_clk) disable iff (srst)
        !active |=> !st_ff.step) else $error("scaled step outside rate modes");
    direct_a: assert property (@(posedge ref_clk) disable iff (srst)
        active && rise && shift == 3'h0 |=> st_ff.step && st_ff.inc == 8'h01)
        else $error("undivided pulse did not step by one");
    ratio_a: assert property (@(posedge ref_clk) disable iff (srst)
        st_ff.step |-> $past(st_ff.div) == $past(mask) && st_ff.inc == $past(dv))
        else $error("step not after ratio pulses");
    filter_a: assert property (@(posedge ref_clk) disable iff (srst)
        filt_en && z && !st_ff.zf && st_ff.fcnt != FILT_LAST |=> !rise || !filt_en)
        else $error("raw pulse passed filter");
endmodule : crps_scal
`default_nettype wire

//--- rtl/crps_per.sv
// 24-bit period meter: clocks between scaled index steps
// assumes tick is a one-cycle pulse from the prescaler
`default_nettype none
module crps_per
    import crps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // measurement control
    input wire logic active,
    input wire logic tick,
    // latched result
    output logic [PER_W-1:0] per,
    output logic ovf
);
    import crps_pkg::*;

    typedef struct packed {
        logic [PER_W-1:0] cnt;
        logic run_ovf;
        logic [PER_W-1:0] lat;
        logic lat_ovf;
    } crps_per_s;

    crps_per_s st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!active) begin
            nxt_st.cnt = '0;
            nxt_st.run_ovf = 1'b0;
        end else if (tick) begin
            nxt_st.lat = st_ff.cnt;
            nxt_st.lat_ovf = st_ff.run_ovf;
            nxt_st.cnt = '0;
            nxt_st.run_ovf = 1'b0;
        end else if (st_ff.cnt == PER_MAX) begin
            nxt_st.run_ovf = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 24'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign per = st_ff.lat;
    assign ovf = st_ff.lat_ovf;

    per_sat_a: assert property (@(posedge ref_clk) disable iff (srst)
        active && !tick && st_ff.cnt == PER_MAX |=> st_ff.cnt == PER_MAX && st_ff.run_ovf)
        else $error("period counter wrapped past 24 bits");
endmodule : crps_per
`default_nettype wire

//--- rtl/crps_top.sv
// two-channel counter with rollover modulus, preset load and index prescaler
// assumes an apb master on ref_clk and counter inputs synchronous to it
//
// Function
// - each channel has its own rollover modulus, set independently
// - up count wraps N-1 to 0; down count wraps 0 to N-1
// - modulus is 32 bits; values above 16,777,216 are held there
// - rate modes ignore the modulus entirely
// - preset-load input loads the channel's preset value
// - scaler divides index pulses only in period/rate and continuous/rate
// - with filter enabled, the filtered index pulse is scaled
// - ratio D advances the count by D every D index pulses
// - scaler bits 0, 1, 2 select divide by 1, 2, 4
// - period counter is 24 bits; overflow is flagged
// - scaler bits 3 to 7 select divide by 8 to 128
//
// Added by the designer: the APB slave port.
`default_nettype none
module crps_top
    import crps_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter inputs, one bit per channel
    input wire logic [1:0] cnt_a,
    input wire logic [1:0] cnt_b,
    input wire logic [1:0] idx_z,
    input wire logic [1:0] preset_load_input
);
    import crps_pkg::*;

    typedef struct packed {
        logic [NCH-1:0] a_q;
        logic [NCH-1:0] b_q;
        logic [NCH-1:0][31:0] cnt;
        logic [NCH-1:0][31:0] mods;
        logic [NCH-1:0][31:0] pre;
        logic [NCH-1:0][15:0] scl;
        logic [7:0] ctrl;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } crps_top_s;

    crps_top_s st_ff, nxt_st;
    crps_mode_e mode [NCH];
    logic [31:0] lim [NCH];
    logic roll [NCH];
    logic scale [NCH];
    logic sc_step [NCH];
    logic [7:0] sc_inc [NCH];
    logic [PER_W-1:0] per [NCH];
    logic per_ovf [NCH];
    logic step [NCH];
    logic up [NCH];
    logic [31:0] inc [NCH];
    logic [5:0] idx;
    logic [31:0] rd;
    logic hit;
    logic ro;
    logic bad;
    logic [31:0] w;
    logic wr_ok;

    assign idx = paddr[7:2];
    assign wr_ok = psel && penable && st_ff.rdy && pwrite && !st_ff.err;

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign mode[g] = crps_mode_e'(st_ff.ctrl[CH_STRIDE*g +: 3]);
        // oversized moduli behave as the largest usable one
        assign lim[g] = (st_ff.mods[g] > MOD_LIMIT) ? MOD_LIMIT : st_ff.mods[g];
        assign roll[g] = crps_uses_roll(mode[g]) && st_ff.mods[g] != 32'h0;
        assign scale[g] = crps_uses_scale(mode[g]);

        crps_scal u_scal (
            .ref_clk(ref_clk),
            .srst(srst),
            .filt_en(st_ff.ctrl[CH_STRIDE*g + FILT_BIT]),
            .scl_word(st_ff.scl[g]),
            .active(scale[g]),
            .z(idx_z[g]),
            .step(sc_step[g]),
            .inc(sc_inc[g])
        );

        crps_per u_per (
            .ref_clk(ref_clk),
            .srst(srst),
            .active(scale[g]),
            .tick(sc_step[g]),
            .per(per[g]),
            .ovf(per_ovf[g])
        );

        up_wrap_a: assert property (@(posedge ref_clk) disable iff (srst)
            step[g] && up[g] && roll[g] && !preset_load_input[g] && st_ff.cnt[g] == lim[g] - 32'h1
            |=> st_ff.cnt[g] == 32'h0) else $error("up count did not wrap to zero");
        down_wrap_a: assert property (@(posedge ref_clk) disable iff (srst)
            step[g] && !up[g] && roll[g] && !preset_load_input[g] && st_ff.cnt[g] == 32'h0
            |=> st_ff.cnt[g] == $past(lim[g]) - 32'h1) else $error("down count did not wrap");
        limit_a: assert property (@(posedge ref_clk) disable iff (srst)
            step[g] && up[g] && roll[g] && !preset_load_input[g] && st_ff.mods[g] > MOD_LIMIT
            && st_ff.cnt[g] == MOD_LIMIT - 32'h1 |=> st_ff.cnt[g] == 32'h0)
            else $error("modulus above usable range honoured");
        preset_a: assert property (@(posedge ref_clk) disable iff (srst)
            preset_load_input[g] |=> st_ff.cnt[g] == $past(st_ff.pre[g]))
            else $error("preset value not loaded");
        rate_free_a: assert property (@(posedge ref_clk) disable iff (srst)
            scale[g] && step[g] && !preset_load_input[g]
            |=> st_ff.cnt[g] == $past(st_ff.cnt[g]) + $past(inc[g]))
            else $error("rate mode count bent by modulus");
        wrap_c: cover property (@(posedge ref_clk) disable iff (srst)
            step[g] && roll[g] && st_ff.cnt[g] == lim[g] - 32'h1 ##1 st_ff.cnt[g] == 32'h0);
        preset_c: cover property (@(posedge ref_clk) disable iff (srst)
            preset_load_input[g] && st_ff.cnt[g] != st_ff.pre[g]);
        ratio_c: cover property (@(posedge ref_clk) disable iff (srst)
            sc_step[g] && sc_inc[g] == 8'h80);
    end

    // register read decode; status words refuse writes
    always_comb begin
        rd = 32'h0;
        hit = 1'b1;
        ro = 1'b0;
        case (idx)
            IDX_MOD0: rd = st_ff.mods[0];
            IDX_MOD1: rd = st_ff.mods[1];
            IDX_PRE0: rd = st_ff.pre[0];
            IDX_PRE1: rd = st_ff.pre[1];
            IDX_SCL0: rd = {16'h0000, st_ff.scl[0]};
            IDX_SCL1: rd = {16'h0000, st_ff.scl[1]};
            IDX_CTRL: rd = {24'h00_0000, st_ff.ctrl};
            IDX_CNT0: begin
                rd = st_ff.cnt[0];
                ro = 1'b1;
            end
            IDX_CNT1: begin
                rd = st_ff.cnt[1];
                ro = 1'b1;
            end
            IDX_PER0: begin
                rd = {7'h00, per_ovf[0], per[0]};
                ro = 1'b1;
            end
            IDX_PER1: begin
                rd = {7'h00, per_ovf[1], per[1]};
                ro = 1'b1;
            end
            default: hit = 1'b0;
        endcase
        bad = !hit || paddr[1:0] != 2'h0 || (pwrite && ro);
        w = crps_wmerge(rd, pwdata, pstrb);
    end

    always_comb begin
        nxt_st = st_ff;
        // one wait state: pready rises the cycle after the access phase opens
        nxt_st.rdy = 1'b0;
        if (psel && penable && !st_ff.rdy) begin
            nxt_st.rdy = 1'b1;
            nxt_st.err = bad;
            nxt_st.rdata = bad ? 32'h0 : rd;
        end
        if (wr_ok) begin
            case (idx)
                IDX_MOD0: nxt_st.mods[0] = w;
                IDX_MOD1: nxt_st.mods[1] = w;
                IDX_PRE0: nxt_st.pre[0] = w;
                IDX_PRE1: nxt_st.pre[1] = w;
                IDX_SCL0: nxt_st.scl[0] = w[15:0];
                IDX_SCL1: nxt_st.scl[1] = w[15:0];
                IDX_CTRL: nxt_st.ctrl = w[7:0];
                default: ;
            endcase
        end
        for (int i = 0; i < NCH; i++) begin
            nxt_st.a_q[i] = cnt_a[i];
            nxt_st.b_q[i] = cnt_b[i];
            step[i] = cnt_a[i] && !st_ff.a_q[i];
            up[i] = !cnt_b[i];
            inc[i] = 32'h1;
            case (mode[i])
                // quadrature: a leading b counts up
                MD_DOUBLE_EDGE: begin
                    step[i] = cnt_a[i] ^ st_ff.a_q[i];
                    up[i] = cnt_a[i] ^ cnt_b[i];
                end
                MD_QUAD_EDGE: begin
                    step[i] = (cnt_a[i] ^ st_ff.a_q[i]) || (cnt_b[i] ^ st_ff.b_q[i]);
                    up[i] = (cnt_a[i] ^ st_ff.a_q[i]) ? (cnt_a[i] ^ cnt_b[i]) : !(cnt_a[i] ^ cnt_b[i]);
                end
                MD_PERIOD_RATE, MD_CONT_RATE: begin
                    step[i] = sc_step[i];
                    up[i] = 1'b1;
                    inc[i] = {24'h00_0000, sc_inc[i]};
                end
                default: ;
            endcase
            // preset wins over a count step in the same cycle
            if (preset_load_input[i]) begin
                nxt_st.cnt[i] = st_ff.pre[i];
            end else if (step[i]) begin
                if (up[i]) begin
                    nxt_st.cnt[i] = (roll[i] && st_ff.cnt[i] >= lim[i] - 32'h1) ? 32'h0
                                  : st_ff.cnt[i] + inc[i];
                end else begin
                    nxt_st.cnt[i] = (roll[i] && st_ff.cnt[i] == 32'h0) ? lim[i] - 32'h1
                                  : st_ff.cnt[i] - inc[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.mods <= {NCH{MOD_RST}};
            st_ff.pre <= {NCH{PRE_RST}};
            st_ff.scl <= {NCH{SCL_RST}};
            st_ff.ctrl <= CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.rdy;
    assign pslverr = st_ff.err;

    apb_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && !pready |=> pready) else $error("apb access not answered");
    pready_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
        pready |=> !pready) else $error("pready held past one cycle");
    unmapped_a: assert property (@(posedge ref_clk) disable iff (srst)
        psel && penable && !pready && !hit |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    ch_indep_a: assert property (@(posedge ref_clk) disable iff (srst)
        wr_ok && idx == IDX_MOD0 |=> st_ff.mods[1] == $past(st_ff.mods[1]) && st_ff.mods[0] == $past(w))
        else $error("channel moduli not independent");
endmodule : crps_top
`default_nettype wire

//--- sim/crps_src.sv
// pulse source model driving the counter inputs of both channels
// assumes one bench process calls its tasks, synchronous to ref_clk
`default_nettype none
module crps_src (
    // clock
    input wire logic ref_clk,
    // counter inputs
    output logic [1:0] cnt_a,
    output logic [1:0] cnt_b,
    output logic [1:0] idx_z,
    output logic [1:0] preset_load_input
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cnt_a = 2'b00;
        cnt_b = 2'b00;
        idx_z = 2'b00;
        preset_load_input = 2'b00;
    end
    // direction settles a cycle ahead of the a edge
    task automatic pulse_a(input int ch, input logic down, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) cnt_b[ch] <= down;
            @(posedge ref_clk) cnt_a[ch] <= 1'b1;
            @(posedge ref_clk);
            @(posedge ref_clk) cnt_a[ch] <= 1'b0;
        end
    endtask : pulse_a
    task automatic pulse_z(input int ch, input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) idx_z[ch] <= 1'b1;
            repeat (hi) @(posedge ref_clk);
            idx_z[ch] <= 1'b0;
            repeat (lo - 1) @(posedge ref_clk);
        end
    endtask : pulse_z
    // gray steps from 00, one state per cycle; a leading b counts up
    task automatic quad(input int ch, input logic down, input int n);
        for (int i = 0; i < n; i++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge ref_clk);
                cnt_a[ch] <= down ? (s == 1 || s == 2) : (s < 2);
                cnt_b[ch] <= down ? (s < 2) : (s == 1 || s == 2);
            end
        end
    endtask : quad
    task automatic load(input int ch);
        @(posedge ref_clk) preset_load_input[ch] <= 1'b1;
        @(posedge ref_clk) preset_load_input[ch] <= 1'b0;
    endtask : load
endmodule : crps_src
`default_nettype wire

//--- sim/crps_top_tb.sv
// self-checking bench for the two-channel counter
// assumes the apb slave answers with pready and the source model drives the inputs
`default_nettype none
module crps_top_tb;
    import crps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk;
    logic srst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [3:0] lanes;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] cnt_a;
    logic [1:0] cnt_b;
    logic [1:0] idx_z;
    logic [1:0] preset_load_input;
    int err_count = 0;
    int check_count = 0;
    logic [31:0] r;
    logic e;
    logic [31:0] m;
    int n;
    int d;

    crps_top DUT (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cnt_a(cnt_a), .cnt_b(cnt_b), .idx_z(idx_z), .preset_load_input(preset_load_input));
    crps_src src (.ref_clk(ref_clk), .cnt_a(cnt_a), .cnt_b(cnt_b), .idx_z(idx_z),
        .preset_load_input(preset_load_input));

    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= lanes;
        @(posedge ref_clk);
        penable <= 1'b1;
        // pready is looked at between edges, where it has settled
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) err_count++;
        rd = prdata;
        er = pslverr;
        // the write lands at this edge; only then is the request released
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
        logic [31:0] x;
        logic y;
        apb(1'b1, idx, wd, x, y);
    endtask : wr
    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        logic y;
        apb(1'b0, idx, 32'h0, x, y);
        chk(x, exp);
    endtask : rdc
    function automatic logic [31:0] wrap_exp(input logic [31:0] v, input int k, input logic [31:0] md,
                                             input logic down);
        logic [31:0] lim;
        lim = (md > MOD_LIMIT) ? MOD_LIMIT : md;
        for (int i = 0; i < k; i++) begin
            v = down ? ((v == 32'h0) ? lim - 32'h1 : v - 32'h1) : ((v == lim - 32'h1) ? 32'h0 : v + 32'h1);
        end
        return v;
    endfunction : wrap_exp
    function automatic logic [31:0] lane_exp(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                v[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return v;
    endfunction : lane_exp
    function automatic logic [31:0] rate_exp(input int k, input int dv);
        return 32'((k / dv) * dv);
    endfunction : rate_exp
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(8 * 60000);
        err_count++;
        print_verdict();
    end

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        lanes = 4'hf;
        void'($urandom(81884));
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        rdc(IDX_MOD0, MOD_RST);
        rdc(IDX_PRE0, PRE_RST);
        rdc(IDX_SCL0, {16'h0, SCL_RST});
        rdc(IDX_CTRL, {24'h0, CTRL_RST});
        apb(1'b0, 6'h3f, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, IDX_CNT0, 32'h5, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test registers done");
        wr(IDX_MOD0, 32'd1000);
        wr(IDX_PRE0, 32'd998);
        src.load(0);
        rdc(IDX_CNT0, 32'd998);
        src.pulse_a(0, 1'b0, 3);
        rdc(IDX_CNT0, wrap_exp(32'd998, 3, 32'd1000, 1'b0));
        wr(IDX_PRE0, 32'd2);
        src.load(0);
        src.pulse_a(0, 1'b1, 3);
        rdc(IDX_CNT0, wrap_exp(32'd2, 3, 32'd1000, 1'b1));
        // oversize modulus behaves as the usable limit
        wr(IDX_MOD0, 32'h0200_0000);
        wr(IDX_PRE0, 32'h00ff_fffe);
        src.load(0);
        src.pulse_a(0, 1'b0, 2);
        rdc(IDX_CNT0, wrap_exp(32'h00ff_fffe, 2, 32'h0200_0000, 1'b0));
        $display("test rollover done");
        m = 32'($urandom_range(2, 9));
        n = $urandom_range(5, 20);
        wr(IDX_MOD1, m);
        wr(IDX_PRE1, 32'h0);
        src.load(1);
        src.pulse_a(1, 1'b0, n);
        rdc(IDX_CNT1, wrap_exp(32'h0, n, m, 1'b0));
        rdc(IDX_MOD0, 32'h0200_0000);
        wr(IDX_MOD1, 32'h0);
        wr(IDX_CTRL, 32'h70);
        src.load(1);
        src.pulse_a(1, 1'b0, 3);
        rdc(IDX_CNT1, 32'd3);
        wr(IDX_MOD1, m);
        wr(IDX_CTRL, 32'h30);
        src.load(1);
        src.quad(1, 1'b1, n);
        rdc(IDX_CNT1, wrap_exp(32'h0, 4 * n, m, 1'b1));
        wr(IDX_CTRL, 32'h20);
        src.load(1);
        src.quad(1, 1'b0, n);
        rdc(IDX_CNT1, wrap_exp(32'h0, 2 * n, m, 1'b0));
        wr(IDX_CTRL, 32'h10);
        src.load(1);
        src.quad(1, 1'b0, n);
        rdc(IDX_CNT1, wrap_exp(32'h0, n, m, 1'b0));
        d = 1 << $urandom_range(0, 3);
        wr(IDX_SCL1, 32'(d));
        wr(IDX_CTRL, 32'h40);
        src.load(1);
        src.pulse_z(1, 2 * d + 1, 2, 3);
        rdc(IDX_CNT1, rate_exp(2 * d + 1, d));
        wr(IDX_PRE1, 32'h1122_3344);
        m = $urandom;
        lanes = 4'($urandom);
        wr(IDX_PRE1, m);
        r = lane_exp(32'h1122_3344, m, lanes);
        lanes = 4'hf;
        rdc(IDX_PRE1, r);
        $display("test channel one done");
        wr(IDX_MOD0, 32'd3);
        wr(IDX_PRE0, 32'h0);
        for (int k = 0; k < 8; k++) begin
            d = 1 << k;
            n = d + $urandom_range(0, d - 1);
            wr(IDX_CTRL, 32'h70);
            wr(IDX_SCL0, 32'(d));
            wr(IDX_CTRL, (k % 2 == 1) ? 32'h7d : 32'h7c);
            src.load(0);
            src.pulse_z(0, n, 5, 5);
            rdc(IDX_CNT0, rate_exp(n, d));
        end
        wr(IDX_CTRL, 32'h70);
        wr(IDX_SCL0, 32'h3);
        wr(IDX_CTRL, 32'h7c);
        src.load(0);
        src.pulse_z(0, 5, 5, 5);
        rdc(IDX_CNT0, 32'd5);
        $display("test scaler done");
        wr(IDX_SCL0, 32'h1);
        src.load(0);
        src.pulse_z(0, 3, 2, 6);
        src.pulse_z(0, 2, 6, 6);
        rdc(IDX_CNT0, 32'd2);
        wr(IDX_CTRL, 32'h74);
        src.pulse_z(0, 4, 1, 9);
        // 10-cycle index period: the meter counts the 9 cycles between two steps
        rdc(IDX_PER0, 32'd9);
        $display("test filter and period done");
        print_verdict();
    end
endmodule : crps_top_tb
`default_nettype wire
